// file: rtl/spi24_map.svh
// Constants for the 24-bit three-wire serial host port
`ifndef SPI24_MAP_SVH
`define SPI24_MAP_SVH

// Frame layout, most significant bit first on the wire
`define SPI24_FRAME_BITS    5'h18
`define SPI24_CTRL_BITS     5'h08
`define SPI24_LAST_BIT      5'h17
`define SPI24_OVERRUN       5'h19
`define SPI24_CTRL_MSB      23
`define SPI24_ID_MSB        7
`define SPI24_ID_LSB        2
`define SPI24_DC_BIT        1
`define SPI24_RW_BIT        0

// Expected identity field; value is arbitrary
`define SPI24_ID_CODE       6'h2a

// Flag encodings
`define SPI24_DC_DATA       1'h1
`define SPI24_RW_READ       1'h1

// Register address that returns link read-back data
`define SPI24_RB_ADDR       8'hff

// Reset values
`define SPI24_ADDR_RST      8'h00
`define SPI24_WORD_RST      16'h0000

// Synchroniser depth
`define SPI24_SYNC_STAGES   2

`endif

// file: rtl/spi24_pkg.sv
// Types and shared decode for the 24-bit three-wire serial host port
`include "spi24_map.svh"
package spi24_pkg;

    // Core-side sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h1,
        ST_FRAME  = 3'h2,
        ST_DECODE = 3'h4
    } port_state_t;

    // Identity field check on an 8-bit control field
    function automatic logic id_ok(input logic [7:0] ctrl);
        id_ok = (ctrl[`SPI24_ID_MSB:`SPI24_ID_LSB] == `SPI24_ID_CODE);
    endfunction

endpackage

// file: rtl/spi24_sync.sv
// Two-flop level synchroniser into the core clock
`timescale 1ns/1ps
module spi24_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage; reset to the idle levels
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            meta   <= rst_val_i;
            sync_o <= rst_val_i;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule

// file: rtl/spi24_link_shift.sv
// Serial-clock side shifter: frame capture and read data drive
`timescale 1ns/1ps
`include "spi24_map.svh"
module spi24_link_shift (
    input  wire logic        sck_i,
    input  wire logic        cs_b_i,
    input  wire logic        rst_b_i,
    input  wire logic        sdin_i,
    input  wire logic [15:0] read_word_i,
    output logic      [23:0] frame_o,
    output logic             done_o,
    output logic             sdout_o,
    output logic             sdout_oe_o
);

    logic [4:0] count;
    logic       rd_mode;
    logic [7:0] ctrl_now;
    logic [4:0] out_idx;
    logic       in_payload;

    assign ctrl_now   = {frame_o[6:0], sdin_i};
    assign out_idx    = `SPI24_LAST_BIT - count;
    assign in_payload = (count >= `SPI24_CTRL_BITS) && (count <= `SPI24_LAST_BIT);

    // Bit counter, cleared by chip select high between cycles
    always_ff @(posedge sck_i or posedge cs_b_i) begin
        if (cs_b_i) begin
            count <= 5'h00;
        end else if (count != `SPI24_OVERRUN) begin
            count <= count + 5'h01;
        end
    end

    // Sample sdin on rising edges, MSB first
    always_ff @(posedge sck_i) begin
        if (count < `SPI24_FRAME_BITS) begin
            frame_o <= {frame_o[22:0], sdin_i};
        end
    end

    // Complete only on exactly 24 bits
    always_ff @(posedge sck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (count == `SPI24_LAST_BIT);
        end
    end

    // Read mode decided at the eighth rising edge
    always_ff @(posedge sck_i or posedge cs_b_i) begin
        if (cs_b_i) begin
            rd_mode <= 1'b0;
        end else if (count == (`SPI24_CTRL_BITS - 5'h01)) begin
            rd_mode <= spi24_pkg::id_ok(ctrl_now) && (sdin_i == `SPI24_RW_READ);
        end
    end

    // Return bits change on falling edges, MSB first
    always_ff @(negedge sck_i or posedge cs_b_i) begin
        if (cs_b_i) begin
            sdout_o    <= 1'b0;
            sdout_oe_o <= 1'b0;
        end else if (rd_mode && in_payload) begin
            sdout_o    <= read_word_i[out_idx[3:0]];
            sdout_oe_o <= 1'b1;
        end else begin
            sdout_o    <= 1'b0;
            sdout_oe_o <= 1'b0;
        end
    end

endmodule

// file: rtl/spi24_three_wire_host_port.sv
// Top of the 24-bit three-wire serial host port
`timescale 1ns/1ps
`include "spi24_map.svh"
// Function
// - Eight control bits then sixteen payload bits
// - Wrong identity field discards whole cycle
// - Control bit seven is data/command flag
// - Control bit eight: one read, zero write
// - Write bits sampled on rising serial clock
// - Payload high byte travels first
// - Read bits driven, changing on falling edges
// - Address FF returns link read-back data
// - PLL reference chosen by select bit
// - Host keeps rate below link throughput
// - Flag one is data, zero command
module spi24_three_wire_host_port (
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        sck_i,
    input  wire logic        cs_b_i,
    input  wire logic        sdin_i,
    output logic             sdout_o,
    output logic             sdout_oe_o,
    input  wire logic        tx_clk_i,
    input  wire logic        pclk_i,
    input  wire logic        pll_ref_select_i,
    output logic             pll_ref_clk_o,
    input  wire logic [15:0] rd_data_i,
    input  wire logic [15:0] rb_data_i,
    output logic      [7:0]  reg_addr_o,
    output logic      [15:0] reg_wdata_o,
    output logic             reg_wr_o,
    output logic             addr_wr_o,
    output logic             rd_done_o,
    output logic             rb_pop_o,
    output logic             frame_drop_o
);

    spi24_pkg::port_state_t state;
    spi24_pkg::port_state_t next_state;

    logic [23:0] link_frame;
    logic        link_done;
    logic [1:0]  sync_q;
    logic        cs_idle;
    logic        frame_ok;
    logic [15:0] read_word;
    logic [7:0]  ctrl;
    logic [15:0] payload;
    logic        id_good;
    logic        is_read;
    logic        is_data;
    logic        take;
    logic        at_rb;
    logic [15:0] next_read_word;

    // Decode, guard and strobe-cause nets
    logic        in_idle;
    logic        in_frame;
    logic        in_decode;
    logic        load_read;
    logic        frame_fresh;
    logic        bad_id;
    logic        bad_count;
    logic        wr_data_hit;
    logic        wr_addr_hit;
    logic        rd_hit;
    logic        rb_hit;
    logic        drop_hit;

    // Serial-clock domain shifter
    spi24_link_shift u_link (
        .sck_i       (sck_i),
        .cs_b_i      (cs_b_i),
        .rst_b_i     (rst_b_i),
        .sdin_i      (sdin_i),
        .read_word_i (read_word),
        .frame_o     (link_frame),
        .done_o      (link_done),
        .sdout_o     (sdout_o),
        .sdout_oe_o  (sdout_oe_o)
    );

    // Chip select and completion level into core clock
    spi24_sync #(
        .WIDTH (2)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .async_i    ({cs_b_i, link_done}),
        .rst_val_i  (2'h2),
        .sync_o     (sync_q)
    );

    assign cs_idle  = sync_q[1];
    assign frame_ok = sync_q[0];

    // Frame word is quiet once chip select is high
    assign ctrl    = link_frame[`SPI24_CTRL_MSB:16];
    assign payload = link_frame[15:0];
    assign id_good = spi24_pkg::id_ok(ctrl);
    assign is_read = (ctrl[`SPI24_RW_BIT] == `SPI24_RW_READ);
    assign is_data = (ctrl[`SPI24_DC_BIT] == `SPI24_DC_DATA);
    assign take    = in_decode && !bad_id && !bad_count;
    assign at_rb   = (reg_addr_o == `SPI24_RB_ADDR);

    // Sequencer state decode
    assign in_idle   = (state == spi24_pkg::ST_IDLE);
    assign in_frame  = (state == spi24_pkg::ST_FRAME);
    assign in_decode = (state == spi24_pkg::ST_DECODE);

    // Snapshot the read word only while the link is quiet
    assign load_read = in_idle && cs_idle;

    // Discard causes: wrong identity, wrong or stale bit count
    assign bad_id    = !id_good;
    assign bad_count = !(frame_ok && frame_fresh);

    // What a taken frame does
    assign wr_data_hit = take && !is_read && is_data;
    assign wr_addr_hit = take && !is_read && !is_data;
    assign rd_hit      = take && is_read;
    assign rb_hit      = rd_hit && at_rb;
    assign drop_hit    = in_decode && !take;

    // Read source: link read-back at address FF
    assign next_read_word = at_rb ? rb_data_i : rd_data_i;

    // Reference clock select for the PLL
    assign pll_ref_clk_o = pll_ref_select_i ? pclk_i : tx_clk_i;

    // Sequencer: each chip-select frame decoded once
    always_comb begin
        next_state = state;
        case (state)
            spi24_pkg::ST_IDLE: begin
                if (!cs_idle) begin
                    next_state = spi24_pkg::ST_FRAME;
                end
            end
            spi24_pkg::ST_FRAME: begin
                if (cs_idle) begin
                    next_state = spi24_pkg::ST_DECODE;
                end
            end
            spi24_pkg::ST_DECODE: begin
                next_state = spi24_pkg::ST_IDLE;
            end
            default: begin
                next_state = spi24_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state <= spi24_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Read word frozen while a frame is in flight
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            read_word <= `SPI24_WORD_RST;
        end else if (load_read) begin
            read_word <= next_read_word;
        end
    end

    // Command writes set the register address
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            reg_addr_o <= `SPI24_ADDR_RST;
        end else if (wr_addr_hit) begin
            reg_addr_o <= payload[7:0];
        end
    end

    // Data writes carry the whole 16-bit word
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            reg_wdata_o <= `SPI24_WORD_RST;
        end else if (wr_data_hit) begin
            reg_wdata_o <= payload;
        end
    end

    // Fresh only if link flag seen low; stops clockless replays
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            frame_fresh <= 1'b0;
        end else if (in_idle) begin
            frame_fresh <= 1'b0;
        end else if (in_frame && !frame_ok) begin
            frame_fresh <= 1'b1;
        end
    end

    // Data write strobe; no flow control toward the host
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            reg_wr_o <= 1'b0;
        end else begin
            reg_wr_o <= wr_data_hit;
        end
    end

    // Address write strobe
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            addr_wr_o <= 1'b0;
        end else begin
            addr_wr_o <= wr_addr_hit;
        end
    end

    // Read done strobe
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rd_done_o <= 1'b0;
        end else begin
            rd_done_o <= rd_hit;
        end
    end

    // Read-back advance strobe
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rb_pop_o <= 1'b0;
        end else begin
            rb_pop_o <= rb_hit;
        end
    end

    // Discard strobe
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            frame_drop_o <= 1'b0;
        end else begin
            frame_drop_o <= drop_hit;
        end
    end

endmodule

// file: tb/spi24_three_wire_host_port_sva.sv
// Core-side timing checks of the 24-bit serial host port
`timescale 1ns/1ps
module spi24_three_wire_host_port_sva (
    input wire logic        core_clk_i,
    input wire logic        rst_b_i,
    input wire logic        cs_b_i,
    input wire logic        sdout_oe_o,
    input wire logic        tx_clk_i,
    input wire logic        pclk_i,
    input wire logic        pll_ref_select_i,
    input wire logic        pll_ref_clk_o,
    input wire logic [7:0]  reg_addr_o,
    input wire logic [15:0] reg_wdata_o,
    input wire logic        reg_wr_o,
    input wire logic        addr_wr_o,
    input wire logic        rd_done_o,
    input wire logic        rb_pop_o,
    input wire logic        frame_drop_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire any_stb = reg_wr_o | addr_wr_o | rd_done_o;

    // Strobe kinds, spacing and cause
    property p_excl; reg_wr_o |-> !addr_wr_o && !rd_done_o && !frame_drop_o; endproperty
    a_excl: assert property (p_excl) else $error("strobe clash");
    property p_pulse; any_stb |=> !any_stb; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe too long");
    property p_after_cs; any_stb |-> $past(cs_b_i, 3); endproperty
    a_after_cs: assert property (p_after_cs) else $error("strobe inside frame");
    property p_pop; rb_pop_o |-> rd_done_o && reg_addr_o == 8'hff; endproperty
    a_pop: assert property (p_pop) else $error("pop off address");
    // Registers only move on their own strobe
    property p_addr_hold; !$stable(reg_addr_o) |-> addr_wr_o; endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_wdata_hold; !$stable(reg_wdata_o) |-> reg_wr_o; endproperty
    a_wdata_hold: assert property (p_wdata_hold) else $error("data moved");
    // Output driver and reference mux
    property p_oe_cs; cs_b_i [*2] |-> !sdout_oe_o; endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("drive outside frame");
    property p_ref; pll_ref_clk_o == (pll_ref_select_i ? pclk_i : tx_clk_i); endproperty
    a_ref: assert property (p_ref) else $error("reference mux");
endmodule

// file: tb/spi24_host_model.sv
// Serial bus master model that frames 24-bit cycles
`timescale 1ns/1ps
module spi24_host_model (
    output logic      cs_b_o,
    output logic      sck_o,
    output logic      sdin_o,
    input  wire logic sdout_i
);
    // Idle bus, clock standing still
    initial begin
        cs_b_o = 1'b1;
        sck_o  = 1'b0;
        sdin_o = 1'b0;
    end

    // One framed cycle of n bits, MSB first
    task automatic xfer(input logic [23:0] f, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        #3 cs_b_o = 1'b0;
        #16;
        for (int i = 23; i > 23 - n; i--) begin
            sdin_o = f[i];
            #16 sck_o = 1'b1;
            if (i < 16) rx[i] = sdout_i;
            #16 sck_o = 1'b0;
        end
        #16 cs_b_o = 1'b1;
        sdin_o = ~sdin_o; // No stale bit once released
        #200;
    endtask
endmodule

// file: tb/spi24_three_wire_host_port_tb.sv
// Self-checking bench for the 24-bit serial host port
`timescale 1ns/1ps
`include "spi24_map.svh"
module spi24_three_wire_host_port_tb;
    logic        core_clk_i = 1'b0, rst_b_i = 1'b0, tx_clk_i = 1'b0, pclk_i = 1'b0;
    logic        pll_ref_select_i = 1'b0, cs_b_i, sck_i, sdin_i, sdout_o, sdout_oe_o;
    logic        pll_ref_clk_o, reg_wr_o, addr_wr_o, rd_done_o, rb_pop_o, frame_drop_o;
    logic [15:0] rd_data_i = 16'ha5c3, rb_data_i = 16'h5a3c, reg_wdata_o, rx;
    logic [7:0]  reg_addr_o;
    int          failures = 0, check_count = 0, n_wr = 0, n_aw = 0, n_rd = 0;
    int          n_pop = 0, n_drop = 0;

    // Clocks
    always #10 core_clk_i = ~core_clk_i;
    always #50 tx_clk_i = ~tx_clk_i;
    always #37 pclk_i = ~pclk_i;

    spi24_three_wire_host_port dut (.*);
    // Released line shows the opposite of the idle drive
    wire         sdout_line = sdout_oe_o ? sdout_o : 1'b1;
    spi24_host_model host (.cs_b_o(cs_b_i), .sck_o(sck_i), .sdin_o(sdin_i), .sdout_i(sdout_line));

    // Strobe tallies
    always @(posedge core_clk_i) begin
        n_wr   <= n_wr + reg_wr_o;
        n_aw   <= n_aw + addr_wr_o;
        n_rd   <= n_rd + rd_done_o;
        n_pop  <= n_pop + rb_pop_o;
        n_drop <= n_drop + frame_drop_o;
    end

    task automatic chk(input string nm, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test;
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic logic [23:0] fr(input logic dc, rw, input logic [15:0] w);
        return {`SPI24_ID_CODE, dc, rw, w};
    endfunction

    // Hang guard
    initial begin
        #100000;
        failures++;
        stop_test();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        chk("addr_rst", 16'h0000, {8'h00, reg_addr_o});
        chk("wdata_rst", 16'h0000, reg_wdata_o);
        host.xfer(fr(1'b0, 1'b0, 16'h0028), 24, rx);
        chk("addr", 16'h0028, {8'h00, reg_addr_o});
        host.xfer(fr(1'b1, 1'b0, 16'h1264), 24, rx);
        chk("wdata", 16'h1264, reg_wdata_o);
        host.xfer(fr(1'b1, 1'b0, 16'h0000), 0, rx);
        host.xfer(fr(1'b1, 1'b1, 16'h0000), 24, rx);
        chk("rdata", 16'ha5c3, rx);
        host.xfer({6'h15, 2'h2, 16'hbeef}, 24, rx);
        host.xfer(fr(1'b1, 1'b0, 16'hbeef), 23, rx);
        chk("wdata_kept", 16'h1264, reg_wdata_o);
        host.xfer({6'h15, 2'h3, 16'h0000}, 24, rx);
        chk("rd_refused", 16'hffff, rx);
        chk("drops", 16'h0004, 16'(n_drop));
        host.xfer(fr(1'b0, 1'b0, 16'h00ff), 24, rx);
        host.xfer(fr(1'b1, 1'b1, 16'h0000), 24, rx);
        chk("rb_data", 16'h5a3c, rx);
        chk("counts", 16'h1221, {4'(n_wr), 4'(n_aw), 4'(n_rd), 4'(n_pop)});
        #7 chk("ref_tx", 16'(tx_clk_i), 16'(pll_ref_clk_o));
        @(posedge core_clk_i) pll_ref_select_i <= 1'b1;
        #7 chk("ref_pclk", 16'(pclk_i), 16'(pll_ref_clk_o));
        stop_test();
    end
endmodule

bind spi24_three_wire_host_port spi24_three_wire_host_port_sva chk_i (.*);
